/* File: rtl/fan_drive_pkg.sv */
// Operation
// - CPU fan PWM source is 24 MHz when clock select is 0, 180 KHz when 1.
// - Selected source is divided by the seven-bit prescaler, then by 256.
// - Clock select and prescaler act only while the CPU fan output is PWM.
// - PWM duty follows the eight-bit value; all ones is 100%, zero is 0%.
// - DC level is upper six bits of the value over 64; low bits reserved.
// - CPU fan mode bits 5-4: manual, temperature, speed, multi-point; manual at reset.
// - System fan mode bits 3-2: manual default, temperature, speed; 11 decodes as manual.
// - Configuration bit 1 picks CPU fan PWM (0, default) or DC (1).
// - Configuration bit 0 picks system fan PWM (0) or DC (1, default).
// - System_target_temp_or_speed: 7-bit target temperature or 8-bit target speed, reset zero.
package fan_drive_pkg;

    // Register indexes behind the address port
    localparam logic [6:0] SYS_FREQ_IDX    = 7'h00;
    localparam logic [6:0] SYS_VALUE_IDX   = 7'h01;
    localparam logic [6:0] CPU_FREQ_IDX    = 7'h02;
    localparam logic [6:0] CPU_VALUE_IDX   = 7'h03;
    localparam logic [6:0] FAN_CONFIG_IDX  = 7'h04;
    localparam logic [6:0] SYS_TARGET_IDX  = 7'h05;

    // Reset values
    localparam logic [7:0] FREQ_RESET      = 8'h04;
    localparam logic [7:0] FAN_CONFIG_RESET = 8'h01;
    localparam logic [7:0] TARGET_RESET    = 8'h00;
    localparam logic [7:0] STRAP_HIGH_VALUE = 8'hFF;
    localparam logic [7:0] STRAP_LOW_VALUE = 8'h80;

    // Field positions
    localparam int FREQ_CLK_SEL_BIT   = 7;
    localparam int CPU_MODE_LSB       = 4;
    localparam int SYS_MODE_LSB       = 2;
    localparam int CPU_TYPE_BIT       = 1;
    localparam int SYS_TYPE_BIT       = 0;
    localparam int DC_LEVEL_LSB       = 2;

    // Source clock rates, in kHz, and the fractional tick accumulator
    localparam int CLK_RATE_KHZ       = 250000;
    localparam int SRC_FAST_KHZ       = 24000;
    localparam int SRC_SLOW_KHZ       = 180;
    localparam int ACC_W              = 18;
    localparam logic [ACC_W:0] ACC_MODULUS  = (ACC_W+1)'(CLK_RATE_KHZ);
    localparam logic [ACC_W:0] ACC_INC_FAST = (ACC_W+1)'(SRC_FAST_KHZ);
    localparam logic [ACC_W:0] ACC_INC_SLOW = (ACC_W+1)'(SRC_SLOW_KHZ);
    localparam logic [7:0] DUTY_FULL  = 8'hFF;

    typedef enum logic [1:0] {
        MODE_MANUAL      = 2'b00,
        MODE_TEMP_TRACK  = 2'b01,
        MODE_SPEED_TRACK = 2'b10,
        MODE_MULTI_POINT = 2'b11
    } fan_mode_e;

endpackage

/* File: rtl/fan_pwm_channel.sv */
`timescale 1ns/1ns
module fan_pwm_channel
    import fan_drive_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       pwm_enable,
    input  wire logic       source_select,
    input  wire logic [6:0] prescale,
    input  wire logic [7:0] duty,
    output logic            pwm_out
);

    logic [ACC_W:0] acc_reg;
    logic [ACC_W:0] acc_sum;
    logic           src_tick;
    logic [6:0]     pre_cnt_reg;
    logic [6:0]     pre_limit;
    logic [7:0]     period_cnt_reg;

    // Fractional source: 250 MHz has no integer ratio to 24 MHz
    assign acc_sum   = acc_reg + (source_select ? ACC_INC_SLOW : ACC_INC_FAST);
    assign src_tick  = (acc_sum >= ACC_MODULUS);
    // Zero prescale would stall; treat it as divide by one
    assign pre_limit = (prescale == 7'h00) ? 7'h00 : prescale - 7'h01;

    // Source phase accumulator, parked in DC mode
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_reg <= '0;
        end else if (!pwm_enable) begin
            acc_reg <= '0;
        end else begin
            acc_reg <= src_tick ? acc_sum - ACC_MODULUS : acc_sum;
        end
    end

    // Prescale then 256-step period
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_cnt_reg    <= '0;
            period_cnt_reg <= '0;
        end else if (!pwm_enable) begin
            pre_cnt_reg    <= '0;
            period_cnt_reg <= '0;
        end else if (src_tick) begin
            if (pre_cnt_reg >= pre_limit) begin
                pre_cnt_reg    <= '0;
                period_cnt_reg <= period_cnt_reg + 8'h01;
            end else begin
                pre_cnt_reg <= pre_cnt_reg + 7'h01;
            end
        end
    end

    // Compare; all ones holds the pin high for the whole period
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pwm_out <= 1'b0;
        end else if (!pwm_enable) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (duty == DUTY_FULL) || (period_cnt_reg < duty);
        end
    end

endmodule // fan_pwm_channel

/* File: rtl/fan_output_drive_config.sv */
`timescale 1ns/1ns
module fan_output_drive_config
    import fan_drive_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       io_data_select,
    input  wire logic       io_write,
    input  wire logic       io_read,
    input  wire logic [7:0] io_wdata,
    output logic [7:0]      io_rdata,
    input  wire logic       fan_set_strap,
    output logic            cpu_fan_output_pwm,
    output logic [5:0]      cpu_fan_output_dc_level,
    output logic            cpu_fan_output_type,
    output logic            system_fan_output_pwm,
    output logic [5:0]      system_fan_output_dc_level,
    output logic            system_fan_output_type,
    output fan_mode_e       cpu_fan_control_mode,
    output fan_mode_e       system_fan_control_mode,
    output logic            cpu_fan_manual,
    output logic            system_fan_manual,
    output logic [6:0]      system_target_temperature,
    output logic [7:0]      system_target_speed
);

    logic [6:0] index_reg;
    logic [7:0] sys_freq_reg;
    logic [7:0] sys_value_reg;
    logic [7:0] cpu_freq_reg;
    logic [7:0] cpu_value_reg;
    logic [7:0] fan_config_reg;
    logic [7:0] target_reg;
    logic       strap_meta_reg;
    logic       strap_sync_reg;
    logic       strap_loaded_reg;
    logic [7:0] strap_value;
    logic       data_write;
    logic [7:0] read_next;
    logic [1:0] pwm_enable;
    logic [1:0] pwm_pin;
    logic [7:0] freq_cfg   [2];
    logic [7:0] duty_value [2];

    assign data_write  = io_write && io_data_select;
    assign strap_value = strap_sync_reg ? STRAP_HIGH_VALUE : STRAP_LOW_VALUE;

    // Strap pin crosses in through two flops. Left out of reset on purpose:
    // the pin level must already be settled when reset lets go.
    always_ff @(posedge clk) begin
        strap_meta_reg <= fan_set_strap;
        strap_sync_reg <= strap_meta_reg;
    end

    // Address port: seven-bit index, bit 7 reserved
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            index_reg <= '0;
        end else if (io_write && !io_data_select) begin
            index_reg <= io_wdata[6:0];
        end
    end

    // System fan frequency register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sys_freq_reg <= FREQ_RESET;
        end else if (data_write && index_reg == SYS_FREQ_IDX) begin
            sys_freq_reg <= io_wdata;
        end
    end

    // CPU fan frequency register; a zero prescale is tolerated downstream
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_freq_reg <= FREQ_RESET;
        end else if (data_write && index_reg == CPU_FREQ_IDX) begin
            cpu_freq_reg <= io_wdata;
        end
    end

    // Fan configuration; reserved bits 7-6 always store zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fan_config_reg <= FAN_CONFIG_RESET;
        end else if (data_write && index_reg == FAN_CONFIG_IDX) begin
            fan_config_reg <= {2'b00, io_wdata[5:0]};
        end
    end

    // Target byte, shared by both tracking modes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            target_reg <= TARGET_RESET;
        end else if (data_write && index_reg == SYS_TARGET_IDX) begin
            target_reg <= io_wdata;
        end
    end

    // Strap default is caught once, in the first cycle after reset release
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_loaded_reg <= 1'b0;
        end else begin
            strap_loaded_reg <= 1'b1;
        end
    end

    // System fan value; a host write in the strap cycle still wins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sys_value_reg <= '0;
        end else if (data_write && index_reg == SYS_VALUE_IDX) begin
            sys_value_reg <= io_wdata;
        end else if (!strap_loaded_reg) begin
            sys_value_reg <= strap_value;
        end
    end

    // CPU fan value; same priority as the system fan
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_value_reg <= '0;
        end else if (data_write && index_reg == CPU_VALUE_IDX) begin
            cpu_value_reg <= io_wdata;
        end else if (!strap_loaded_reg) begin
            cpu_value_reg <= strap_value;
        end
    end

    // Read mux; unmapped indexes read zero
    always_comb begin
        read_next = 8'h00;
        if (!io_data_select) begin
            read_next = {1'b0, index_reg};
        end else begin
            case (index_reg)
                SYS_FREQ_IDX:   read_next = sys_freq_reg;
                SYS_VALUE_IDX:  read_next = sys_value_reg;
                CPU_FREQ_IDX:   read_next = cpu_freq_reg;
                CPU_VALUE_IDX:  read_next = cpu_value_reg;
                FAN_CONFIG_IDX: read_next = fan_config_reg;
                SYS_TARGET_IDX: read_next = target_reg;
                default:        read_next = 8'h00;
            endcase
        end
    end

    // Read data held until the next read strobe
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            io_rdata <= '0;
        end else if (io_read) begin
            io_rdata <= read_next;
        end
    end

    // Output type per fan
    assign cpu_fan_output_type    = fan_config_reg[CPU_TYPE_BIT];
    assign system_fan_output_type = fan_config_reg[SYS_TYPE_BIT];
    assign pwm_enable = {!cpu_fan_output_type, !system_fan_output_type};

    // Channel 0 system fan, channel 1 CPU fan
    assign freq_cfg[0]   = sys_freq_reg;
    assign freq_cfg[1]   = cpu_freq_reg;
    assign duty_value[0] = sys_value_reg;
    assign duty_value[1] = cpu_value_reg;

    // One PWM engine per fan
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            fan_pwm_channel u_chan (
                .clk           (clk),
                .sys_rst       (sys_rst),
                .pwm_enable    (pwm_enable[ch]),
                .source_select (freq_cfg[ch][FREQ_CLK_SEL_BIT]),
                .prescale      (freq_cfg[ch][6:0]),
                .duty          (duty_value[ch]),
                .pwm_out       (pwm_pin[ch])
            );
        end
    endgenerate

    assign system_fan_output_pwm = pwm_pin[0];
    assign cpu_fan_output_pwm    = pwm_pin[1];

    // DC level codes for the external DAC, zero while in PWM mode
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_fan_output_dc_level    <= '0;
            system_fan_output_dc_level <= '0;
        end else begin
            cpu_fan_output_dc_level    <= cpu_fan_output_type ?
                                          cpu_value_reg[7:DC_LEVEL_LSB] : 6'h00;
            system_fan_output_dc_level <= system_fan_output_type ?
                                          sys_value_reg[7:DC_LEVEL_LSB] : 6'h00;
        end
    end

    // Mode decode toward the control engine
    assign cpu_fan_control_mode = fan_mode_e'(fan_config_reg[CPU_MODE_LSB +: 2]);
    always_comb begin
        case (fan_config_reg[SYS_MODE_LSB +: 2])
            2'b01:   system_fan_control_mode = MODE_TEMP_TRACK;
            2'b10:   system_fan_control_mode = MODE_SPEED_TRACK;
            default: system_fan_control_mode = MODE_MANUAL;
        endcase
    end
    assign cpu_fan_manual    = (cpu_fan_control_mode == MODE_MANUAL);
    assign system_fan_manual = (system_fan_control_mode == MODE_MANUAL);

    // Target register seen both ways; bit 7 ignored for temperature
    assign system_target_temperature = target_reg[6:0];
    assign system_target_speed       = target_reg;

endmodule // fan_output_drive_config

/* File: testbench/fan_drive_checker.sv */
`timescale 1ns/1ns
module fan_drive_checker
    import fan_drive_pkg::*;
(
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       io_read,
    input wire logic [7:0] io_rdata,
    input wire logic       cpu_fan_output_pwm,
    input wire logic [5:0] cpu_fan_output_dc_level,
    input wire logic       cpu_fan_output_type,
    input wire logic       system_fan_output_pwm,
    input wire logic [5:0] system_fan_output_dc_level,
    input wire logic       system_fan_output_type,
    input wire fan_mode_e  cpu_fan_control_mode,
    input wire fan_mode_e  system_fan_control_mode,
    input wire logic       cpu_fan_manual,
    input wire logic       system_fan_manual,
    input wire logic [6:0] system_target_temperature,
    input wire logic [7:0] system_target_speed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // DC mode parks the pin low; three cycles cover the registered pin lag
    cpu_dc_quiet_a: assert property (cpu_fan_output_type [*3] |-> !cpu_fan_output_pwm)
        else $error("cpu pwm pin active in dc mode");
    sys_dc_quiet_a: assert property (system_fan_output_type [*3] |-> !system_fan_output_pwm)
        else $error("system pwm pin active in dc mode");
    // Level output only carries a value while the fan is in DC mode
    cpu_level_idle_a: assert property (!cpu_fan_output_type [*2] |-> cpu_fan_output_dc_level == 6'h00)
        else $error("cpu dc level driven in pwm mode");
    sys_level_idle_a: assert property (!system_fan_output_type [*2] |-> system_fan_output_dc_level == 6'h00)
        else $error("system dc level driven in pwm mode");
    manual_flag_a: assert property ((cpu_fan_manual == (cpu_fan_control_mode == MODE_MANUAL)) && (system_fan_manual == (system_fan_control_mode == MODE_MANUAL)))
        else $error("manual flag disagrees with mode");
    sys_mode_legal_a: assert property (system_fan_control_mode != MODE_MULTI_POINT)
        else $error("system fan shows reserved mode");
    target_view_a: assert property (system_target_temperature == system_target_speed[6:0])
        else $error("target temperature and speed views differ");
    reset_state_a: assert property ($fell(sys_rst) |-> !cpu_fan_output_type && system_fan_output_type && cpu_fan_manual && system_fan_manual && system_target_speed == 8'h00)
        else $error("outputs wrong after reset");
    read_hold_a: assert property (!io_read |=> $stable(io_rdata))
        else $error("read data moved without a read");

    cover property (cpu_fan_output_type && cpu_fan_output_dc_level != 6'h00);
    cover property ($rose(cpu_fan_output_pwm));
    cover property (system_fan_control_mode == MODE_SPEED_TRACK);
endmodule // fan_drive_checker

bind fan_output_drive_config fan_drive_checker u_fan_drive_checker (
    .clk(clk), .sys_rst(sys_rst), .io_read(io_read), .io_rdata(io_rdata),
    .cpu_fan_output_pwm(cpu_fan_output_pwm), .cpu_fan_output_dc_level(cpu_fan_output_dc_level),
    .cpu_fan_output_type(cpu_fan_output_type), .system_fan_output_pwm(system_fan_output_pwm),
    .system_fan_output_dc_level(system_fan_output_dc_level),
    .system_fan_output_type(system_fan_output_type),
    .cpu_fan_control_mode(cpu_fan_control_mode), .system_fan_control_mode(system_fan_control_mode),
    .cpu_fan_manual(cpu_fan_manual), .system_fan_manual(system_fan_manual),
    .system_target_temperature(system_target_temperature),
    .system_target_speed(system_target_speed)
);

/* File: testbench/fan_load_model.sv */
`timescale 1ns/1ns
module fan_load_model (
    input  wire logic  clk,
    input  wire logic  fan_pin,
    output logic [31:0] high_len,
    output logic [31:0] period_len
);
    logic [31:0] run_cnt  = 32'h0;
    logic        pin_last = 1'b0;

    // The fan only sees edges, so it times high pulse and period in clocks
    always_ff @(posedge clk) begin
        pin_last <= fan_pin;
        run_cnt  <= run_cnt + 32'h1;
        if (fan_pin && !pin_last) begin
            period_len <= run_cnt;
            run_cnt    <= 32'h1;
        end
        if (!fan_pin && pin_last) begin
            high_len <= run_cnt;
        end
    end
endmodule // fan_load_model

/* File: testbench/testbench.sv */
`timescale 1ns/1ns
module testbench;
    import fan_drive_pkg::*;
    logic clk, sys_rst, io_data_select, io_write, io_read, fan_set_strap;
    logic [7:0] io_wdata, io_rdata;
    logic cpu_pwm, cpu_type, sys_pwm, sys_type, cpu_man, sys_man;
    logic [5:0] cpu_lvl, sys_lvl;
    fan_mode_e cpu_mode, sys_mode;
    logic [6:0] tgt_temp;
    logic [7:0] tgt_speed;
    logic [31:0] high_len, period_len;
    int n_errors = 0;
    int samples_checked = 0;

    fan_output_drive_config u_fan_output_drive_config (
        .clk(clk), .sys_rst(sys_rst), .io_data_select(io_data_select), .io_write(io_write),
        .io_read(io_read), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .fan_set_strap(fan_set_strap), .cpu_fan_output_pwm(cpu_pwm),
        .cpu_fan_output_dc_level(cpu_lvl), .cpu_fan_output_type(cpu_type),
        .system_fan_output_pwm(sys_pwm), .system_fan_output_dc_level(sys_lvl),
        .system_fan_output_type(sys_type), .cpu_fan_control_mode(cpu_mode),
        .system_fan_control_mode(sys_mode), .cpu_fan_manual(cpu_man),
        .system_fan_manual(sys_man), .system_target_temperature(tgt_temp),
        .system_target_speed(tgt_speed));
    fan_load_model u_fan_load_model (
        .clk(clk), .fan_pin(cpu_pwm), .high_len(high_len), .period_len(period_len));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic wrap_up;
        if (n_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got,
                       input int tol = 0);
        samples_checked++;
        if ($isunknown(got) || got > exp + tol || got + tol < exp) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // One strobe per access; the idle edge keeps each strobe a single pulse
    task automatic acc(input logic sel, input logic wr, input logic [7:0] d);
        io_data_select <= sel;
        io_write <= wr;
        io_read <= !wr;
        io_wdata <= d;
        @(posedge clk);
        io_write <= 1'b0;
        io_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        acc(1'b0, 1'b1, idx);
        acc(1'b1, 1'b1, d);
        repeat (2) @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string name);
        acc(1'b0, 1'b1, idx);
        acc(1'b1, 1'b0, 8'h00);
        chk(name, exp, io_rdata);
    endtask

    task automatic t_reset;
        rd(8'h02, 8'h04, "freq_reset");
        rd(8'h04, 8'h01, "config_reset");
        rd(8'h05, 8'h00, "target_reset");
        rd(8'h03, STRAP_HIGH_VALUE, "value_strap");
        chk("sys_dc_level", 32'h3F, sys_lvl);
        chk("cpu_type", 32'h0, cpu_type);
        chk("sys_type", 32'h1, sys_type);
        rd(8'h40, 8'h00, "unmapped_read");
    endtask

    task automatic t_modes;
        for (int m = 0; m < 4; m++) begin
            wr(8'h04, 8'(m * 20));
            chk("cpu_mode", m, cpu_mode);
            chk("sys_mode", (m == 3) ? 0 : m, sys_mode);
            chk("cpu_manual", m == 0, cpu_man);
            chk("sys_manual", m == 0 || m == 3, sys_man);
        end
        chk("sys_pin_full", 32'h1, sys_pwm);
    endtask

    task automatic t_target;
        wr(8'h05, 8'hA5);
        chk("target_speed", 32'hA5, tgt_speed);
        chk("target_temp", 32'h25, tgt_temp);
    endtask

    task automatic t_dc;
        wr(8'h04, 8'h02);
        wr(8'h02, 8'h01);
        wr(8'h03, 8'hB7);
        chk("cpu_dc_level", 32'h2D, cpu_lvl);
        repeat (3000) @(posedge clk);
        chk("cpu_pin_in_dc", 32'h0, cpu_pwm);
    endtask

    // Fast source: 256 ticks of 24 MHz span 2666.7 clocks per prescale step
    task automatic t_pwm;
        wr(8'h04, 8'h00);
        wr(8'h03, 8'h40);
        repeat (8100) @(posedge clk);
        chk("period_p1", 2667, period_len, 2);
        chk("high_p1", 667, high_len, 2);
        wr(8'h02, 8'h03);
        repeat (24100) @(posedge clk);
        chk("period_p3", 8000, period_len, 2);
        chk("high_p3", 2000, high_len, 2);
        wr(8'h03, 8'hFF);
        repeat (8100) @(posedge clk);
        chk("pin_full", 32'h1, cpu_pwm);
        wr(8'h03, 8'h00);
        repeat (8100) @(posedge clk);
        chk("pin_zero", 32'h0, cpu_pwm);
    endtask

    // Slow source: one 180 KHz tick lasts 1388.9 clocks, seen as the first pulse
    task automatic t_slow;
        wr(8'h04, 8'h02);
        wr(8'h02, 8'h81);
        wr(8'h03, 8'h01);
        wr(8'h04, 8'h00);
        repeat (3000) @(posedge clk);
        chk("high_slow", 1389, high_len, 2);
    endtask

    initial begin
        sys_rst = 1'b1;
        io_data_select = 1'b0;
        io_write = 1'b0;
        io_read = 1'b0;
        io_wdata = 8'h00;
        fan_set_strap = 1'b1;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_modes();
        t_target();
        t_dc();
        t_pwm();
        t_slow();
        wrap_up();
    end

    // Scenarios need about 55k cycles; a hang stops well past that
    initial begin
        repeat (90000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
endmodule // testbench
